// *** ccalm_top.sv ***
// Decided for this implementation: the AXI4-Lite slave port.
module ccalm_top #(
    parameter int DIV_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ref_tick,
    input wire logic [ccalm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ccalm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import ccalm_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Register offsets are word aligned and contiguous
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'b00) && (a <= OFF_LAST);
    endfunction

    // Byte lanes and writable bits together decide what changes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = mask & {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (data & m);
    endfunction

    function automatic logic [4:0] month_length(input logic [3:0] month, input logic leap);
        logic [4:0] len;
        len = 5'd31;
        if (month == 4'd2) begin
            len = leap ? 5'd29 : 5'd28;
        end else if (month == 4'd4 || month == 4'd6 || month == 4'd9 || month == 4'd11) begin
            len = 5'd30;
        end
        return len;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic aw_free_reg, w_free_reg, ar_free_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [DIV_W-1:0] divider_reg;
    logic [31:0] date_setup_reg, time_setup_reg;
    logic [31:0] alarm_date_reg, alarm_time_reg;
    logic enable_reg, load_reg, non_leap_reg, running_reg;
    logic match_active_reg, match_prev_reg;
    logic irq_raw_reg, irq_enable_reg, irq_force_reg, irq_reg;
    logic [DIV_W-1:0] count_reg;
    ccalm_date_t cur_date_reg, date_snap_reg;
    ccalm_time_t cur_time_reg;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // A write runs one cycle after both address and data are held
    wire wr_exec = !aw_free_reg && !w_free_reg && !bvalid_reg;
    wire wr_ok = wr_exec && is_mapped(waddr_reg);
    wire wr_divider = wr_ok && waddr_reg == OFF_SECOND_DIVIDER;
    wire wr_date = wr_ok && waddr_reg == OFF_DATE_SETUP;
    wire wr_time = wr_ok && waddr_reg == OFF_TIME_SETUP;
    wire wr_ctrl = wr_ok && waddr_reg == OFF_CONTROL_STATUS;
    wire wr_alarm_date = wr_ok && waddr_reg == OFF_ALARM_DATE;
    wire wr_alarm_time = wr_ok && waddr_reg == OFF_ALARM_TIME;
    wire wr_irq_raw = wr_ok && waddr_reg == OFF_IRQ_RAW;
    wire wr_irq_enable = wr_ok && waddr_reg == OFF_IRQ_ENABLE;
    wire wr_irq_force = wr_ok && waddr_reg == OFF_IRQ_FORCE;
    wire lane0 = wstrb_reg[0];
    wire lane1 = wstrb_reg[1];
    wire aw_take = s_axi_awvalid && aw_free_reg;
    wire w_take = s_axi_wvalid && w_free_reg;
    wire ar_take = s_axi_arvalid && ar_free_reg;
    wire b_done = bvalid_reg && s_axi_bready;
    wire r_done = rvalid_reg && s_axi_rready;
    wire rd_snap = ar_take && s_axi_araddr == OFF_CURRENT_TIME;

    // ----------------------------------------
    // Alarm compare
    // ----------------------------------------
    wire ccalm_date_t al_date = unpack_date(alarm_date_reg);
    wire ccalm_time_t al_time = unpack_time(alarm_time_reg);
    wire m_year = !alarm_date_reg[AD_YEAR_EN_BIT] || al_date.year == cur_date_reg.year;
    wire m_month = !alarm_date_reg[AD_MONTH_EN_BIT] || al_date.month == cur_date_reg.month;
    wire m_day = !alarm_date_reg[AD_DAY_EN_BIT] || al_date.day == cur_date_reg.day;
    wire m_wday = !alarm_time_reg[AT_WEEKDAY_EN_BIT] || al_time.weekday == cur_time_reg.weekday;
    wire m_hour = !alarm_time_reg[AT_HOUR_EN_BIT] || al_time.hour == cur_time_reg.hour;
    wire m_min = !alarm_time_reg[AT_MINUTE_EN_BIT] || al_time.minute == cur_time_reg.minute;
    wire m_sec = !alarm_time_reg[AT_SECOND_EN_BIT] || al_time.second == cur_time_reg.second;
    // Gated by the active flag, not the raw enable bit
    wire match_now = match_active_reg && m_year && m_month && m_day && m_wday && m_hour && m_min && m_sec;
    // Edge, so a partial alarm fires once per matching stretch
    wire match_event = match_now && !match_prev_reg;
    wire irq_status = (irq_raw_reg && irq_enable_reg) || irq_force_reg;

    // ----------------------------------------
    // Calendar next state
    // ----------------------------------------
    // Leap years are years divisible by four unless overridden
    wire leap = cur_date_reg.year[1:0] == 2'b00 && !non_leap_reg;
    wire [4:0] last_day = month_length(cur_date_reg.month, leap);
    // Divider field is the count minus one
    wire sec_tick = ref_tick && running_reg && count_reg == divider_reg;
    wire apply_load = ref_tick && load_reg;
    wire sec_wrap = cur_time_reg.second >= SECOND_LAST;
    wire min_wrap = sec_wrap && cur_time_reg.minute >= MINUTE_LAST;
    wire hour_wrap = min_wrap && cur_time_reg.hour >= HOUR_LAST;
    wire day_wrap = hour_wrap && cur_date_reg.day >= last_day;
    wire month_wrap = day_wrap && cur_date_reg.month >= MONTH_LAST;
    wire [2:0] wday_inc = cur_time_reg.weekday >= WEEKDAY_LAST ? 3'h0 : cur_time_reg.weekday + 3'h1;
    ccalm_time_t time_next;
    ccalm_date_t date_next;
    assign time_next.second = sec_wrap ? 6'h00 : cur_time_reg.second + 6'h01;
    assign time_next.minute = min_wrap ? 6'h00 : (sec_wrap ? cur_time_reg.minute + 6'h01 : cur_time_reg.minute);
    assign time_next.hour = hour_wrap ? 5'h00 : (min_wrap ? cur_time_reg.hour + 5'h01 : cur_time_reg.hour);
    assign time_next.weekday = hour_wrap ? wday_inc : cur_time_reg.weekday;
    assign date_next.day = day_wrap ? DAY_FIRST : (hour_wrap ? cur_date_reg.day + 5'h01 : cur_date_reg.day);
    assign date_next.month = month_wrap ? MONTH_FIRST :
                             (day_wrap ? cur_date_reg.month + 4'h1 : cur_date_reg.month);
    assign date_next.year = month_wrap ? cur_date_reg.year + 12'h001 : cur_date_reg.year;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [31:0] ctrl_word = {23'h0, non_leap_reg, 3'h0, load_reg, 2'h0, running_reg, enable_reg};
    wire [31:0] alarm_date_word = alarm_date_reg | ({31'h0, match_active_reg} << AD_ACTIVE_BIT);
    wire [31:0] rd_word =
        s_axi_araddr == OFF_SECOND_DIVIDER ? 32'(divider_reg) :
        s_axi_araddr == OFF_DATE_SETUP ? date_setup_reg :
        s_axi_araddr == OFF_TIME_SETUP ? time_setup_reg :
        s_axi_araddr == OFF_CONTROL_STATUS ? ctrl_word :
        s_axi_araddr == OFF_ALARM_DATE ? alarm_date_word :
        s_axi_araddr == OFF_ALARM_TIME ? alarm_time_reg :
        s_axi_araddr == OFF_CURRENT_DATE ? pack_date(date_snap_reg) :
        s_axi_araddr == OFF_CURRENT_TIME ? pack_time(cur_time_reg) :
        s_axi_araddr == OFF_IRQ_RAW ? {31'h0, irq_raw_reg} :
        s_axi_araddr == OFF_IRQ_ENABLE ? {31'h0, irq_enable_reg} :
        s_axi_araddr == OFF_IRQ_FORCE ? {31'h0, irq_force_reg} :
        s_axi_araddr == OFF_IRQ_STATUS ? {31'h0, irq_status} : WORD_RESET;

    // ----------------------------------------
    // Write channels
    // ----------------------------------------
    // Address and data taken in either order, freed by the response
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_free_reg <= 1'b1;
            w_free_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            waddr_reg <= '0;
            wdata_reg <= WORD_RESET;
            wstrb_reg <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_free_reg <= 1'b0;
                waddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_free_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_exec) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= is_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_done) begin
                bvalid_reg <= 1'b0;
                aw_free_reg <= 1'b1;
                w_free_reg <= 1'b1;
            end
        end
    end

    // Read channel; one cycle from address to data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ar_free_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= WORD_RESET;
        end else if (ar_take) begin
            ar_free_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= is_mapped(s_axi_araddr) ? rd_word : WORD_RESET;
            rresp_reg <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (r_done) begin
            ar_free_reg <= 1'b1;
            rvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Setup and alarm registers
    // ----------------------------------------
    // Divider not guarded: software stops the clock before changing it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            divider_reg <= DIVIDER_RESET;
            date_setup_reg <= WORD_RESET;
            time_setup_reg <= WORD_RESET;
        end else begin
            if (wr_divider) begin
                divider_reg <= DIV_W'(merge(32'(divider_reg), wdata_reg, wstrb_reg, MASK_DIVIDER));
            end
            if (wr_date) begin
                date_setup_reg <= merge(date_setup_reg, wdata_reg, wstrb_reg, MASK_DATE);
            end
            if (wr_time) begin
                time_setup_reg <= merge(time_setup_reg, wdata_reg, wstrb_reg, MASK_TIME);
            end
        end
    end

    // Alarm words keep the setup layout plus enable bits
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            alarm_date_reg <= WORD_RESET;
            alarm_time_reg <= WORD_RESET;
        end else begin
            if (wr_alarm_date) begin
                alarm_date_reg <= merge(alarm_date_reg, wdata_reg, wstrb_reg, MASK_ALARM_DATE);
            end
            if (wr_alarm_time) begin
                alarm_time_reg <= merge(alarm_time_reg, wdata_reg, wstrb_reg, MASK_ALARM_TIME);
            end
        end
    end

    // Control bits; a new load request wins over the self-clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            enable_reg <= 1'b0;
            non_leap_reg <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            if (wr_ctrl && lane0) begin
                enable_reg <= wdata_reg[CTRL_ENABLE_BIT];
            end
            if (wr_ctrl && lane1) begin
                non_leap_reg <= wdata_reg[CTRL_NON_LEAP_BIT];
            end
            if (wr_ctrl && lane0 && wdata_reg[CTRL_LOAD_BIT]) begin
                load_reg <= 1'b1;
            end else if (apply_load) begin
                load_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Reference side
    // ----------------------------------------
    // Flags change only on a reference edge, so polling sees the crossing
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            running_reg <= 1'b0;
            match_active_reg <= 1'b0;
        end else if (ref_tick) begin
            running_reg <= enable_reg;
            match_active_reg <= alarm_date_reg[AD_GLOBAL_EN_BIT];
        end
    end

    // Divider counter; a load restarts the second
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (apply_load || sec_tick) begin
            count_reg <= '0;
        end else if (ref_tick && running_reg) begin
            count_reg <= count_reg + DIV_W'(1);
        end
    end

    // Running calendar; load works even while running
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur_date_reg <= unpack_date(WORD_RESET);
            cur_time_reg <= unpack_time(WORD_RESET);
        end else if (apply_load) begin
            cur_date_reg <= unpack_date(date_setup_reg);
            cur_time_reg <= unpack_time(time_setup_reg);
        end else if (sec_tick) begin
            cur_date_reg <= date_next;
            cur_time_reg <= time_next;
        end
    end

    // Date captured by the time-word read, so a torn rollover cannot show
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            date_snap_reg <= unpack_date(WORD_RESET);
        end else if (rd_snap) begin
            date_snap_reg <= cur_date_reg;
        end
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    // Sticky raw bit, write one to clear; a new match wins over the clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            match_prev_reg <= 1'b0;
            irq_raw_reg <= 1'b0;
            irq_enable_reg <= 1'b0;
            irq_force_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            match_prev_reg <= match_now;
            if (match_event) begin
                irq_raw_reg <= 1'b1;
            end else if (wr_irq_raw && lane0 && wdata_reg[IRQ_BIT]) begin
                irq_raw_reg <= 1'b0;
            end
            if (wr_irq_enable && lane0) begin
                irq_enable_reg <= wdata_reg[IRQ_BIT];
            end
            if (wr_irq_force && lane0) begin
                irq_force_reg <= wdata_reg[IRQ_BIT];
            end
            irq_reg <= irq_status;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_awready = aw_free_reg;
    assign s_axi_wready = w_free_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ar_free_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign irq = irq_reg;

endmodule

// *** ccalm_pkg.sv ***
package ccalm_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_SECOND_DIVIDER = 8'h00;
    localparam logic [7:0] OFF_DATE_SETUP = 8'h04;
    localparam logic [7:0] OFF_TIME_SETUP = 8'h08;
    localparam logic [7:0] OFF_CONTROL_STATUS = 8'h0C;
    localparam logic [7:0] OFF_ALARM_DATE = 8'h10;
    localparam logic [7:0] OFF_ALARM_TIME = 8'h14;
    localparam logic [7:0] OFF_CURRENT_DATE = 8'h18;
    localparam logic [7:0] OFF_CURRENT_TIME = 8'h1C;
    localparam logic [7:0] OFF_IRQ_RAW = 8'h20;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
    localparam logic [7:0] OFF_IRQ_FORCE = 8'h28;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h2C;
    localparam logic [7:0] OFF_LAST = 8'h2C;

    // ----------------------------------------
    // Writable bits per register
    // ----------------------------------------
    localparam logic [31:0] MASK_DIVIDER = 32'h0000FFFF;
    localparam logic [31:0] MASK_DATE = 32'h00FFFF1F;
    localparam logic [31:0] MASK_TIME = 32'h071F3F3F;
    localparam logic [31:0] MASK_ALARM_DATE = 32'h17FFFF1F;
    localparam logic [31:0] MASK_ALARM_TIME = 32'hF71F3F3F;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RUNNING_BIT = 1;
    localparam int CTRL_LOAD_BIT = 4;
    localparam int CTRL_NON_LEAP_BIT = 8;
    localparam int AD_DAY_EN_BIT = 24;
    localparam int AD_MONTH_EN_BIT = 25;
    localparam int AD_YEAR_EN_BIT = 26;
    localparam int AD_GLOBAL_EN_BIT = 28;
    localparam int AD_ACTIVE_BIT = 29;
    localparam int AT_SECOND_EN_BIT = 28;
    localparam int AT_MINUTE_EN_BIT = 29;
    localparam int AT_HOUR_EN_BIT = 30;
    localparam int AT_WEEKDAY_EN_BIT = 31;
    localparam int IRQ_BIT = 0;
    localparam logic [15:0] DIVIDER_RESET = 16'h0000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;

    // ----------------------------------------
    // Calendar limits and bus response codes
    // ----------------------------------------
    localparam logic [5:0] SECOND_LAST = 6'h3B;
    localparam logic [5:0] MINUTE_LAST = 6'h3B;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [3:0] MONTH_LAST = 4'hC;
    localparam logic [3:0] MONTH_FIRST = 4'h1;
    localparam logic [4:0] DAY_FIRST = 5'h01;
    localparam logic [2:0] WEEKDAY_LAST = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [11:0] year;
        logic [3:0] month;
        logic [4:0] day;
    } ccalm_date_t;

    typedef struct packed {
        logic [2:0] weekday;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } ccalm_time_t;

    function automatic logic [31:0] pack_date(input ccalm_date_t d);
        return {8'h00, d.year, d.month, 3'h0, d.day};
    endfunction

    function automatic ccalm_date_t unpack_date(input logic [31:0] w);
        return '{year: w[23:12], month: w[11:8], day: w[4:0]};
    endfunction

    function automatic logic [31:0] pack_time(input ccalm_time_t t);
        return {5'h00, t.weekday, 3'h0, t.hour, 2'h0, t.minute, 2'h0, t.second};
    endfunction

    function automatic ccalm_time_t unpack_time(input logic [31:0] w);
        return '{weekday: w[26:24], hour: w[20:16], minute: w[13:8], second: w[5:0]};
    endfunction

endpackage

// *** ccalm_properties.sv ***
module ccalm_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ccalm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    import ccalm_pkg::*;
    // ----------------------------------------
    // Bus handshake and interrupt checks
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response not two edges after the pair");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready while response pending");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not retired");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one edge after address");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data not retired");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFF_LAST
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000) else $error("unmapped read not refused");
    a_mapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= OFF_LAST
        && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
    a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
endmodule

bind ccalm_top ccalm_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// *** testbench.sv ***
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin errors++; $display("unexpected at %0t: %s", $time, m); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ccalm_pkg::*;
    logic clk_sys = 0, rst_n = 0, ref_tick = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [2:0] tcnt = 3'h0;
    int errors = 0, num_checks = 0, n;
    // Reference clock stands in as one enable pulse every eight cycles
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        tcnt <= tcnt + 3'h1;
        ref_tick <= (tcnt == 3'h3);
    end
    ccalm_top #(.DIV_W(16)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ref_tick(ref_tick), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq));
    // ----------------------------------------
    // Verdict and bus tasks
    // ----------------------------------------
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Write: address and data offered together, each dropped once taken
    // Response ready stays high, so back to back calls never toggle it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            k++;
            if (k > 200) begin errors++; wrap_up(); end
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
    endtask
    // Read: data and response captured at the edge that retires them
    task automatic rdw(input logic [7:0] a);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            k++;
            if (k > 200) begin errors++; wrap_up(); end
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        rdw(a);
        `CHK(rd, e, "read data")
        `CHK(rs, r, "read response")
    endtask
    // Poll a field, bounded so a stuck clock ends the run
    task automatic wait_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        n = 0;
        do begin rdw(a); n++; end while ((rd & m) !== v && n < 100);
        `CHK(rd & m, v, "poll timed out")
        if ((rd & m) !== v) wrap_up();
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk_rd(OFF_SECOND_DIVIDER, 32'h00000000, RESP_OKAY);
        chk_rd(OFF_ALARM_TIME, 32'h00000000, RESP_OKAY);
        chk_rd(OFF_IRQ_STATUS, 32'h00000000, RESP_OKAY);
        chk_rd(8'h30, 32'h00000000, RESP_SLVERR);
        wr(8'h30, 32'hFFFFFFFF);
        `CHK(rs, RESP_SLVERR, "unmapped write response")
        wr(OFF_SECOND_DIVIDER, 32'hFFFF1234);
        `CHK(rs, RESP_OKAY, "write response")
        chk_rd(OFF_SECOND_DIVIDER, 32'h00001234, RESP_OKAY);
        wr(OFF_SECOND_DIVIDER, 32'h00000001);
        wr(OFF_DATE_SETUP, 32'h0006421C);
        chk_rd(OFF_DATE_SETUP, 32'h0006421C, RESP_OKAY);
        wr(OFF_TIME_SETUP, 32'hFF173B3B);
        chk_rd(OFF_TIME_SETUP, 32'h07173B3B, RESP_OKAY);
        wr(OFF_TIME_SETUP, 32'h06173B3B);
        // Load, enable and non-leap override in one write
        wr(OFF_CONTROL_STATUS, 32'h00000111);
        wait_rd(OFF_CONTROL_STATUS, 32'h00000002, 32'h00000002);
        `CHK(rd, 32'h00000103, "control word after load")
        wait_rd(OFF_CURRENT_TIME, 32'h0000003F, 32'h00000000);
        `CHK(rd, 32'h00000000, "midnight rollover")
        chk_rd(OFF_CURRENT_DATE, 32'h00064301, RESP_OKAY);
        // Seconds-only alarm; fields set before the global enable
        wr(OFF_IRQ_ENABLE, 32'h00000001);
        // Hour and minute fields differ from the time but are not enabled
        wr(OFF_ALARM_TIME, 32'h10173B03);
        wr(OFF_ALARM_DATE, 32'h10000000);
        n = 0;
        while (!irq && n < 400) begin @(posedge clk_sys); n++; end
        `CHK(irq, 1'b1, "alarm interrupt")
        if (!irq) wrap_up();
        rdw(OFF_CURRENT_TIME);
        `CHK(rd[5:0], 6'h03, "alarm second")
        chk_rd(OFF_ALARM_DATE, 32'h30000000, RESP_OKAY);
        wr(OFF_IRQ_RAW, 32'h00000001);
        chk_rd(OFF_IRQ_STATUS, 32'h00000000, RESP_OKAY);
        `CHK(irq, 1'b0, "interrupt cleared")
        wr(OFF_ALARM_DATE, 32'h00000000);
        wr(OFF_IRQ_ENABLE, 32'h00000000);
        wr(OFF_IRQ_FORCE, 32'h00000001);
        chk_rd(OFF_IRQ_STATUS, 32'h00000001, RESP_OKAY);
        `CHK(irq, 1'b1, "forced interrupt")
        wr(OFF_IRQ_FORCE, 32'h00000000);
        chk_rd(OFF_IRQ_STATUS, 32'h00000000, RESP_OKAY);
        wrap_up();
    end
endmodule
